// ### verilog/uart_fifo_test_cfg.svh
// Purpose: register offsets, field positions and reset values of the
//   fifo test-access and status register bank
// Assumes: 32-bit register port, byte addresses
// Notes: definitions only
// Contract
// [R1] test-access bit 0 enables pushing rx and popping tx by software; resets 0
// [R2] without the test-access option, writes to the control bit are ignored
// [R3] fifos absent or off: test access uses rx buffer and tx holding regs
// [R4] toggling test access resets both fifos' control to empty
// [R5] fifo mode: tx test read returns head byte and pops it
// [R6] fifo off: tx test read returns tx holding register
// [R7] software uses test registers only while test access is on
// [R8] without the option the test registers read zero and do nothing
// [R9] fifo mode: rx test write pushes its data byte into rx fifo
// [R10] rx test write bit 9 is the pushed entry's framing-error tag
// [R11] rx test write bit 8 is the pushed entry's parity-error tag
// [R12] fifo off: rx test write loads data and tags into rx buffer
// [R13] status bit 4 shows rx fifo full; resets 0
// [R14] status bit 3 shows rx fifo not empty; resets 0
// [R15] status bit 2 shows tx fifo empty; resets 1
// [R16] status bit 1 shows tx fifo not full; resets 1
// [R17] busy on transmit activity or held tx data with divisor set and access clear
// [R18] busy also on receive activity or held rx data with test access off
// [R19] busy may miss a start bit until its mid-bit acceptance
// [R20] with a separate serial clock busy rises several slow cycles late
// [R21] busy exists only without legacy option; status bits 31:5 read zero
// [R22] tx level register reports tx fifo entry count; resets zero
// [R23] divisor latch access is line control bit 7
// [R24] fifos enabled only when fifo control bit 0 is set
// [R25] test registers accessed with test access off change nothing
`ifndef UART_FIFO_TEST_CFG_SVH
`define UART_FIFO_TEST_CFG_SVH
`define ADDR_TEST_CTRL 8'h70
`define ADDR_TX_TEST_READ 8'h74
`define ADDR_RX_TEST_WRITE 8'h78
`define ADDR_STATUS 8'h7c
`define ADDR_TX_LEVEL 8'h80
`define ADDR_LINE_CTRL 8'h0c
`define ADDR_FIFO_CTRL 8'h08
`define ADDR_DIVISOR 8'h00
`define ADDR_SIM_CTRL 8'h98
`define ADDR_RX_POP 8'h9c
`define BIT_TEST_ENABLE 0
`define BIT_PARITY_TAG 8
`define BIT_FRAMING_TAG 9
`define BIT_RX_FULL 4
`define BIT_RX_NONEMPTY 3
`define BIT_TX_EMPTY 2
`define BIT_TX_NOTFULL 1
`define BIT_BUSY 0
`define BIT_DIVISOR_LATCH_ACCESS 7
`define BIT_FIFO_ENABLE 0
`define BIT_TX_PUSH 0
`define BIT_TX_ACTIVE 1
`define BIT_RX_ACTIVE 2
`define RESET_TEST_CTRL 1'h0
`define RESET_STATUS 5'h06
`endif

// ### verilog/uart_fifo_test_pkg.sv
// Purpose: shared types of the fifo test-access register bank
// Assumes: 8-bit characters with two error tags
// Notes: offsets live in the cfg header
package uart_fifo_test_pkg;
  // one receive entry: data byte and its error tags
  typedef struct packed {
    logic framingErr;
    logic parityErr;
    logic [7:0] data;
  } rx_entry_s;

  // register port request
  typedef struct packed {
    logic wrStb;
    logic rdStb;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_s;
endpackage : uart_fifo_test_pkg

// ### verilog/uart_fifo_test_status.sv
// Purpose: fifo test access, fifo status, tx level and busy reporting
// Assumes: one 40 MHz clock, plain register port, read data one cycle later
// Notes: serial engines are outside; their activity arrives as inputs
//
// Chosen here: the address-and-strobe port.
`include "uart_fifo_test_cfg.svh"
`timescale 1ns/10ps
module uart_fifo_test_status #(
  parameter int DEPTH = 16,
  parameter bit TEST_ACCESS_OPT = 1'b1,
  parameter bit FIFO_PRESENT = 1'b1,
  parameter bit LEGACY_COMPAT = 1'b0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // register port
  input wire uart_fifo_test_pkg::reg_req_s regReq,
  output logic [31:0] regRdata,
  // serial engine activity, same clock domain
  input wire logic txActive,
  input wire logic rxActive,
  input wire logic txPop,
  input wire logic rxPush,
  input wire uart_fifo_test_pkg::rx_entry_s rxPushEntry,
  // receive head towards the rest of the uart
  output uart_fifo_test_pkg::rx_entry_s rxHead,
  output logic rxHeadValid
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("DEPTH must be a power of two, at least 2");
    end
  end

  logic testOn_reg;
  logic [7:0] lineCtrl_reg;
  logic fifoCtrl_reg;
  logic [15:0] divisor_reg;
  logic [2:0] simCtrl_reg;
  logic [7:0] txMem [DEPTH];
  uart_fifo_test_pkg::rx_entry_s rxMem [DEPTH];
  logic [AW-1:0] txWr_reg, txRd_reg, rxWr_reg, rxRd_reg;
  logic [AW:0] txCnt_reg, rxCnt_reg;
  logic [7:0] txHold_reg;
  logic txHoldFull_reg;
  uart_fifo_test_pkg::rx_entry_s rxBuf_reg;
  logic rxBufFull_reg;
  logic [4:0] status_reg;
  logic [31:0] regRdata_reg;

  logic wr, rd, fifoOn, testWr, testRd, toggle;
  logic txPushSw, txPopAll, rxPushAll, rxPopSw;
  uart_fifo_test_pkg::rx_entry_s testEntry, rxIn;
  logic txHeld, rxHeld;

  // decode; fifos count only with the enable bit set
  assign wr = regReq.wrStb;
  assign rd = regReq.rdStb;
  assign fifoOn = FIFO_PRESENT && fifoCtrl_reg; // [R24] [R3]
  assign toggle = wr && regReq.addr == `ADDR_TEST_CTRL && TEST_ACCESS_OPT
    && (regReq.wdata[`BIT_TEST_ENABLE] != testOn_reg); // [R2] [R4]
  // test registers act only with the option and the mode on
  assign testWr = TEST_ACCESS_OPT && testOn_reg && wr
    && regReq.addr == `ADDR_RX_TEST_WRITE; // [R25] [R8]
  assign testRd = TEST_ACCESS_OPT && testOn_reg && rd
    && regReq.addr == `ADDR_TX_TEST_READ; // [R25] [R8]
  assign testEntry.framingErr = regReq.wdata[`BIT_FRAMING_TAG]; // [R10]
  assign testEntry.parityErr = regReq.wdata[`BIT_PARITY_TAG]; // [R11]
  assign testEntry.data = regReq.wdata[7:0];
  assign txPushSw = wr && regReq.addr == `ADDR_SIM_CTRL
    && regReq.wdata[`BIT_TX_PUSH];
  // in test mode the serial side is cut off from the fifos
  assign txPopAll = fifoOn && txCnt_reg != '0
    && (testRd || (!testOn_reg && txPop)); // [R5]
  assign rxPushAll = fifoOn && rxCnt_reg != FULL_CNT
    && (testWr || (!testOn_reg && rxPush)); // [R9]
  assign rxIn = testWr ? testEntry : rxPushEntry;
  assign rxPopSw = rd && regReq.addr == `ADDR_RX_POP;
  // held data: the fifo when enabled, else the single holding registers
  assign txHeld = fifoOn ? (txCnt_reg != '0) : txHoldFull_reg; // [R17]
  assign rxHeld = fifoOn ? (rxCnt_reg != '0) : rxBufFull_reg; // [R18]

  // control registers written by software
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      testOn_reg <= `RESET_TEST_CTRL;
      lineCtrl_reg <= 8'h00;
      fifoCtrl_reg <= 1'b0;
      divisor_reg <= 16'h0000;
      simCtrl_reg <= 3'h0;
    end else if (wr) begin
      unique case (regReq.addr)
        `ADDR_TEST_CTRL: begin
          if (TEST_ACCESS_OPT) begin
            testOn_reg <= regReq.wdata[`BIT_TEST_ENABLE]; // [R1] [R2]
          end
        end
        `ADDR_LINE_CTRL: lineCtrl_reg <= regReq.wdata[7:0];
        `ADDR_FIFO_CTRL: fifoCtrl_reg <= regReq.wdata[`BIT_FIFO_ENABLE];
        `ADDR_DIVISOR: divisor_reg <= regReq.wdata[15:0];
        `ADDR_SIM_CTRL: simCtrl_reg <= regReq.wdata[2:0];
        default: ;
      endcase
    end
  end

  // transmit fifo pointers; toggle of test mode empties it
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      txWr_reg <= '0;
      txRd_reg <= '0;
      txCnt_reg <= '0;
    end else if (toggle || !fifoOn) begin
      txWr_reg <= '0; // [R4]
      txRd_reg <= '0;
      txCnt_reg <= '0;
    end else begin
      if (txPushSw && txCnt_reg != FULL_CNT) begin
        txWr_reg <= txWr_reg + 1'b1;
      end
      if (txPopAll) begin
        txRd_reg <= txRd_reg + 1'b1; // [R5]
      end
      if ((txPushSw && txCnt_reg != FULL_CNT) && !txPopAll) begin
        txCnt_reg <= txCnt_reg + 1'b1;
      end else if (!(txPushSw && txCnt_reg != FULL_CNT) && txPopAll) begin
        txCnt_reg <= txCnt_reg - 1'b1;
      end
    end
  end

  // transmit storage; data feed comes through the sim control word
  always_ff @(posedge sys_clk) begin
    if (txPushSw && fifoOn && txCnt_reg != FULL_CNT) begin
      txMem[txWr_reg] <= regReq.wdata[15:8];
    end
  end

  // receive fifo pointers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rxWr_reg <= '0;
      rxRd_reg <= '0;
      rxCnt_reg <= '0;
    end else if (toggle || !fifoOn) begin
      rxWr_reg <= '0; // [R4]
      rxRd_reg <= '0;
      rxCnt_reg <= '0;
    end else begin
      if (rxPushAll) begin
        rxWr_reg <= rxWr_reg + 1'b1; // [R9]
      end
      if (rxPopSw && rxCnt_reg != '0) begin
        rxRd_reg <= rxRd_reg + 1'b1;
      end
      if (rxPushAll && !(rxPopSw && rxCnt_reg != '0)) begin
        rxCnt_reg <= rxCnt_reg + 1'b1;
      end else if (!rxPushAll && rxPopSw && rxCnt_reg != '0) begin
        rxCnt_reg <= rxCnt_reg - 1'b1;
      end
    end
  end

  // receive storage keeps both error tags with the byte
  always_ff @(posedge sys_clk) begin
    if (rxPushAll) begin
      rxMem[rxWr_reg] <= rxIn; // [R9] [R10] [R11]
    end
  end

  // single holding and buffer registers used with fifos off
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      txHold_reg <= 8'h00;
      txHoldFull_reg <= 1'b0;
      rxBuf_reg <= '0;
      rxBufFull_reg <= 1'b0;
    end else begin
      if (txPushSw && !fifoOn) begin
        txHold_reg <= regReq.wdata[15:8];
        txHoldFull_reg <= 1'b1;
      end else if (!fifoOn && !testOn_reg && txPop) begin
        txHoldFull_reg <= 1'b0;
      end
      // an incoming byte overwrites, as an overrun would
      if (!fifoOn && (testWr || (!testOn_reg && rxPush))) begin
        rxBuf_reg <= rxIn; // [R12]
        rxBufFull_reg <= 1'b1;
      end else if (!fifoOn && rxPopSw) begin
        rxBufFull_reg <= 1'b0;
      end
    end
  end

  // status flags, registered so a read sees a stable snapshot
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      status_reg <= `RESET_STATUS; // [R15] [R16]
    end else begin
      status_reg[`BIT_RX_FULL] <= rxCnt_reg == FULL_CNT; // [R13]
      status_reg[`BIT_RX_NONEMPTY] <= rxCnt_reg != '0; // [R14]
      status_reg[`BIT_TX_EMPTY] <= txCnt_reg == '0; // [R15]
      status_reg[`BIT_TX_NOTFULL] <= txCnt_reg != FULL_CNT; // [R16]
      // start bits count only once the receiver reports activity;
      // one clock only, so busy lags by this single register stage
      status_reg[`BIT_BUSY] <= !LEGACY_COMPAT && (txActive || simCtrl_reg[1]
        || (txHeld && !testOn_reg && divisor_reg != 16'h0000
        && !lineCtrl_reg[`BIT_DIVISOR_LATCH_ACCESS]) // [R17] [R23] [R20]
        || rxActive || simCtrl_reg[2]
        || (rxHeld && !testOn_reg)); // [R18] [R19] [R21]
    end
  end

  // read data, valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      regRdata_reg <= 32'h00000000;
    end else if (rd) begin
      unique case (regReq.addr)
        `ADDR_TEST_CTRL: regRdata_reg <= {31'h0, testOn_reg}; // [R2]
        `ADDR_TX_TEST_READ: begin
          if (!testRd) begin
            regRdata_reg <= 32'h00000000; // [R8]
          end else if (fifoOn) begin
            regRdata_reg <= {24'h0, txMem[txRd_reg]}; // [R5]
          end else begin
            regRdata_reg <= {24'h0, txHold_reg}; // [R6] [R3]
          end
        end
        `ADDR_STATUS: regRdata_reg <= {27'h0, status_reg}; // [R21]
        `ADDR_TX_LEVEL: regRdata_reg <= 32'(txCnt_reg); // [R22]
        `ADDR_LINE_CTRL: regRdata_reg <= {24'h0, lineCtrl_reg};
        `ADDR_FIFO_CTRL: regRdata_reg <= {31'h0, fifoCtrl_reg};
        `ADDR_DIVISOR: regRdata_reg <= {16'h0, divisor_reg};
        `ADDR_SIM_CTRL: regRdata_reg <= {29'h0, simCtrl_reg};
        `ADDR_RX_POP: begin
          regRdata_reg <= fifoOn ? 32'(rxMem[rxRd_reg]) : 32'(rxBuf_reg);
        end
        default: regRdata_reg <= 32'h00000000;
      endcase
    end else begin
      regRdata_reg <= 32'h00000000;
    end
  end

  // receive head mirrors to the rest of the uart
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rxHead <= '0;
      rxHeadValid <= 1'b0;
    end else begin
      rxHead <= fifoOn ? rxMem[rxRd_reg] : rxBuf_reg;
      rxHeadValid <= fifoOn ? (rxCnt_reg != '0) : rxBufFull_reg;
    end
  end

  assign regRdata = regRdata_reg;
endmodule : uart_fifo_test_status

// ### verification/uart_fifo_test_status_properties.sv
// Purpose: port-level checks of the fifo test and status register bank
// Assumes: test-access option built in, fifos present, default parameters
// Notes: bound to every instance of the bank
`timescale 1ns/10ps
module uart_fifo_test_status_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // register port
  input wire uart_fifo_test_pkg::reg_req_s regReq,
  input wire logic [31:0] regRdata,
  // serial side
  input wire logic txActive,
  input wire logic rxActive,
  input wire logic rxPush,
  input wire logic rxHeadValid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic testOn;
  wire logic rdCtl = regReq.rdStb && regReq.addr == 8'h70;
  wire logic rdTx = regReq.rdStb && regReq.addr == 8'h74;
  wire logic rdSt = regReq.rdStb && regReq.addr == 8'h7c;
  wire logic rdLvl = regReq.rdStb && regReq.addr == 8'h80;
  wire logic wrCtl = regReq.wrStb && regReq.addr == 8'h70;
  wire logic flip = wrCtl && regReq.wdata[0] != testOn && !rxPush;

  // mirror of the test-access bit, so toggles can be told from rewrites
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      testOn <= 1'b0;
    else if (wrCtl)
      testOn <= regReq.wdata[0];
  end

  property p_idle; !regReq.rdStb |=> regRdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("data without read");
  property p_ctl; rdCtl |=> regRdata == {31'h0, testOn}; endproperty
  a_ctl: assert property (p_ctl) else $error("control readback");
  property p_txw; rdTx |=> regRdata[31:8] == 24'h0; endproperty
  a_txw: assert property (p_txw) else $error("tx read width");
  property p_txoff; rdTx && !testOn |=> regRdata == 32'h0; endproperty
  a_txoff: assert property (p_txoff) else $error("tx read off");
  property p_stw; rdSt |=> regRdata[31:5] == 27'h0; endproperty
  a_stw: assert property (p_stw) else $error("status upper bits");
  property p_lvw; rdLvl |=> regRdata[31:5] == 27'h0; endproperty
  a_lvw: assert property (p_lvw) else $error("level upper bits");
  property p_full; rdSt |=> !regRdata[4] || regRdata[3]; endproperty
  a_full: assert property (p_full) else $error("full but empty");
  property p_txf; rdSt |=> !(regRdata[2] && !regRdata[1]); endproperty
  a_txf: assert property (p_txf) else $error("tx empty and full");
  property p_btx; rdSt && txActive && $past(txActive) |=> regRdata[0];
  endproperty
  a_btx: assert property (p_btx) else $error("busy missed tx");
  property p_brx; rdSt && rxActive && $past(rxActive) |=> regRdata[0];
  endproperty
  a_brx: assert property (p_brx) else $error("busy missed rx");
  // a toggle empties the rx fifo, so with fifos enabled the head goes invalid
  property p_flip; flip |=> ##[0:1] !rxHeadValid; endproperty
  a_flip: assert property (p_flip) else $error("toggle kept rx");
endmodule : uart_fifo_test_status_checker

bind uart_fifo_test_status uart_fifo_test_status_checker u_chk (
  .sys_clk(sys_clk),
  .resetn(resetn),
  .regReq(regReq),
  .regRdata(regRdata),
  .txActive(txActive),
  .rxActive(rxActive),
  .rxPush(rxPush),
  .rxHeadValid(rxHeadValid)
);

// ### verification/uart_fifo_test_status_tb.sv
// Purpose: register-level test of the fifo test and status bank
// Assumes: default parameters, depth 16
// Notes: serial side is driven directly by the bench
`timescale 1ns/10ps
module uart_fifo_test_status_tb;
  logic sys_clk;
  logic resetn;
  uart_fifo_test_pkg::reg_req_s regReq;
  logic [31:0] regRdata;
  logic txActive;
  logic rxActive;
  logic txPop;
  logic rxPush;
  uart_fifo_test_pkg::rx_entry_s rxPushEntry;
  uart_fifo_test_pkg::rx_entry_s rxHead;
  logic rxHeadValid;
  int n_mismatch;
  int n_checks;
  int i;
  logic [31:0] rdv;

  uart_fifo_test_status DUT (.sys_clk(sys_clk), .resetn(resetn),
    .regReq(regReq), .regRdata(regRdata), .txActive(txActive),
    .rxActive(rxActive), .txPop(txPop), .rxPush(rxPush),
    .rxPushEntry(rxPushEntry), .rxHead(rxHead), .rxHeadValid(rxHeadValid));

  // 40 MHz
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one access; read data is taken in the cycle after the strobe
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regReq <= '{wrStb: w, rdStb: !w, addr: a, wdata: d};
    @(posedge sys_clk);
    regReq <= '0;
    @(negedge sys_clk);
    rdv = regRdata;
  endtask : acc

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask : rdchk

  task automatic txb(input logic [7:0] b);
    acc(1'b1, 8'h98, {16'h0, b, 8'h01});
  endtask : txb

  task automatic end_of_test();
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // main sequence
  initial begin
    resetn = 1'b0;
    regReq = '0;
    txActive = 1'b0;
    rxActive = 1'b0;
    txPop = 1'b0;
    rxPush = 1'b0;
    rxPushEntry = '0;
    n_mismatch = 0;
    n_checks = 0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    rdchk(8'h70, 32'h0);
    rdchk(8'h7c, 32'h6);
    rdchk(8'h80, 32'h0);
    rdchk(8'h44, 32'h0);
    @(posedge sys_clk);
    txActive <= 1'b1;
    rdchk(8'h7c, 32'h7);
    @(posedge sys_clk);
    txActive <= 1'b0;
    rxActive <= 1'b1;
    rdchk(8'h7c, 32'h7);
    @(posedge sys_clk);
    rxActive <= 1'b0;
    rdchk(8'h7c, 32'h6);
    // held tx data counts as busy unless divisor access is open
    acc(1'b1, 8'h08, 32'h1);
    acc(1'b1, 8'h00, 32'h1);
    txb(8'ha5);
    rdchk(8'h7c, 32'h3);
    acc(1'b1, 8'h0c, 32'h80);
    rdchk(8'h7c, 32'h2);
    acc(1'b1, 8'h0c, 32'h0);
    @(posedge sys_clk);
    txPop <= 1'b1;
    @(posedge sys_clk);
    txPop <= 1'b0;
    rdchk(8'h80, 32'h0);
    @(posedge sys_clk);
    rxPushEntry <= 10'h1c3;
    rxPush <= 1'b1;
    @(posedge sys_clk);
    rxPush <= 1'b0;
    rdchk(8'h7c, 32'hf);
    rdchk(8'h9c, 32'h1c3);
    // test registers while test access is off
    acc(1'b1, 8'h78, 32'h0ff);
    rdchk(8'h7c, 32'h6);
    rdchk(8'h74, 32'h0);
    txb(8'h11);
    txb(8'h12);
    rdchk(8'h80, 32'h2);
    // from here test registers are used only with test access on
    acc(1'b1, 8'h70, 32'h1);
    rdchk(8'h70, 32'h1);
    rdchk(8'h80, 32'h0);
    for (i = 0; i < 16; i++)
      txb(8'h30 + i[7:0]);
    rdchk(8'h80, 32'h10);
    rdchk(8'h7c, 32'h0);
    for (i = 0; i < 16; i++)
      rdchk(8'h74, {24'h0, 8'h30 + i[7:0]});
    rdchk(8'h7c, 32'h6);
    for (i = 0; i < 16; i++)
      acc(1'b1, 8'h78, {22'h0, i[1:0], 8'hc0 + i[7:0]});
    rdchk(8'h7c, 32'h1e);
    for (i = 0; i < 16; i++)
      rdchk(8'h9c, {22'h0, i[1:0], 8'hc0 + i[7:0]});
    rdchk(8'h7c, 32'h6);
    acc(1'b1, 8'h78, 32'h155);
    acc(1'b1, 8'h70, 32'h0);
    // the head valid flag is registered once more after the pointers
    @(negedge sys_clk);
    chk({31'h0, rxHeadValid}, 32'h0);
    // fifos off: test access goes to the single buffers
    acc(1'b1, 8'h08, 32'h0);
    acc(1'b1, 8'h70, 32'h1);
    acc(1'b1, 8'h78, 32'h2c3);
    @(negedge sys_clk);
    chk({22'h0, rxHead}, 32'h2c3);
    txb(8'h5e);
    rdchk(8'h74, 32'h5e);
    end_of_test();
  end
endmodule : uart_fifo_test_status_tb
